// ### pkg/csda_cfg.svh
// offsets, field positions, reset values and encodings of the compare-skip / decimal adjust block
`ifndef CSDA_CFG_SVH
`define CSDA_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CSDA_OFF_CTRL     12'h000
`define CSDA_OFF_INSTR    12'h004
`define CSDA_OFF_WORK     12'h008
`define CSDA_OFF_STATUS   12'h00c
`define CSDA_OFF_BANK     12'h010
`define CSDA_OFF_INDEX    12'h014
`define CSDA_OFF_RESULT   12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSDA_CTRL_EXT     0
`define CSDA_CTRL_TWO     1
`define CSDA_STAT_C       0
`define CSDA_STAT_DC      1
`define CSDA_INSTR_BUSY   16
`define CSDA_RES_SKIP     0
`define CSDA_RES_CYC_LSB  1
`define CSDA_RES_BAD      3
`define CSDA_RES_EA_LSB   16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSDA_RST_WORK     8'h00
`define CSDA_RST_BANK     4'h0
`define CSDA_RST_INDEX    12'h000

// ----------------------------------------------------------------
// opcode encodings, upper seven bits of compare words, whole word for decimal adjust
// ----------------------------------------------------------------
`define CSDA_OP_LT        7'h30
`define CSDA_OP_EQ        7'h31
`define CSDA_OP_GT        7'h32
`define CSDA_OP_DAA       16'h0007

// ----------------------------------------------------------------
// addressing and correction constants
// ----------------------------------------------------------------
`define CSDA_INDEX_LIMIT  8'h5f
`define CSDA_ACCESS_HIGH  4'hf
`define CSDA_ACCESS_LOW   4'h0
`define CSDA_BCD_MAX      4'h9
`define CSDA_BCD_FIX      4'h6
`define CSDA_NOP_ONE      2'h1
`define CSDA_NOP_TWO      2'h2
`define CSDA_CYC_ONE      2'h1

`endif

// ### pkg/csda_pkg.sv
// types shared by the compare-skip / decimal adjust block
`default_nettype none
package csda_pkg;

    // execution sequencer states, one-hot
    typedef enum logic [5:0] {
        CSDA_ST_IDLE = 6'b000001,
        CSDA_ST_Q1   = 6'b000010,
        CSDA_ST_Q2   = 6'b000100,
        CSDA_ST_Q3   = 6'b001000,
        CSDA_ST_Q4   = 6'b010000,
        CSDA_ST_NOP  = 6'b100000
    } csda_state_t;

    // decoded instruction kind, one-hot
    typedef enum logic [4:0] {
        CSDA_K_LT  = 5'b00001,
        CSDA_K_EQ  = 5'b00010,
        CSDA_K_GT  = 5'b00100,
        CSDA_K_DAA = 5'b01000,
        CSDA_K_BAD = 5'b10000
    } csda_kind_t;

endpackage : csda_pkg
`default_nettype wire

// ### hw/csda_nibble_adj.sv
// one decimal-adjust nibble corrector
`timescale 1ns/1ns
`default_nettype none
`include "csda_cfg.svh"
module csda_nibble_adj
(
    input  wire logic [3:0] nib_in,     // nibble before correction
    input  wire logic       force_fix,  // carry flag that forces correction
    output logic      [3:0] nib_out,    // nibble after correction
    output logic            fixed       // correction applied
);

    // correct when the digit is out of range or the carry says so
    always_comb
    begin
        fixed   = (nib_in > `CSDA_BCD_MAX) || force_fix;
        nib_out = fixed ? 4'(nib_in + `CSDA_BCD_FIX) : nib_in;
    end

endmodule : csda_nibble_adj
`default_nettype wire

// ### hw/csda_core.sv
// compare-and-skip and decimal adjust execution unit with apb register access
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "csda_cfg.svh"
module csda_core
    import csda_pkg::*;
#(
    parameter int ADDR_W = 12,  // data memory address width
    parameter int BANK_W = 4    // bank select width
)
(
    input  wire logic              pclk,         // core clock, one q phase per edge
    input  wire logic              presetn,      // asynchronous reset, active low
    input  wire logic              psel,         // apb select
    input  wire logic              penable,      // apb access phase
    input  wire logic              pwrite,       // apb direction
    input  wire logic [11:0]       paddr,        // apb byte address
    input  wire logic [31:0]       pwdata,       // apb write data
    output logic      [31:0]       prdata,       // apb read data
    output logic                   pready,       // apb ready
    output logic                   pslverr,      // apb error
    output logic      [ADDR_W-1:0] file_addr,    // data memory address
    output logic                   file_rd,      // data memory read strobe, q2
    input  wire logic [7:0]        file_rdata,   // data memory read data, valid in q3
    output logic      [3:0]        q_phase,      // active q phase, one-hot
    output logic                   nop_cycle,    // discarded fetch executing as no-op
    output logic                   busy          // instruction in progress
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W != BANK_W + 8)
    begin : g_bad_width
        $error("address width must be bank width plus eight");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    csda_state_t             state_r;        // sequencer state
    csda_state_t             state_nxt;      // next sequencer state
    csda_kind_t              kind_r;         // decoded instruction kind
    logic [15:0]             instr_r;        // instruction word under execution
    logic                    ext_en_r;       // extended instruction set enabled
    logic                    two_word_r;     // prefetched instruction is two-word
    logic [7:0]              work_r;         // working_register
    logic                    carry_r;        // carry flag
    logic                    dcarry_r;       // digit_carry_flag
    logic [BANK_W-1:0]       bank_r;         // bank_select_register
    logic [ADDR_W-1:0]       index_r;        // index base for literal offset mode
    logic                    skip_r;         // compare decided to skip
    logic [1:0]              nop_left_r;     // no-op instruction cycles remaining
    logic [1:0]              cycles_r;       // instruction cycles of last instruction
    logic                    bad_r;          // last opcode not recognised
    logic [7:0]              daa_op_r;       // working register copy read in q2
    logic [7:0]              daa_res_r;      // adjusted value from q3
    logic                    daa_c_r;        // carry from q3
    logic [31:0]             rd_mux;         // readback selection
    logic                    addr_ok;        // mapped offset
    logic                    wr_ro;          // write to read-only register
    logic                    apb_setup;      // setup phase of a transfer
    logic                    wr_ok;          // accepted write this edge
    logic                    start;          // instruction written
    logic [7:0]              f_lit;          // file address field
    logic [ADDR_W-1:0]       ea;             // effective data address
    logic [8:0]              diff;           // file minus working register
    logic                    cmp_skip;       // compare condition met
    logic [3:0]              lo_adj;         // corrected low nibble
    logic [3:0]              hi_adj;         // corrected high nibble
    logic                    lo_fix;         // low nibble corrected
    logic                    hi_fix;         // high nibble corrected

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign apb_setup = psel & ~penable;
    assign wr_ok     = psel & penable & pready & pwrite & ~pslverr;
    assign start     = wr_ok && (paddr == `CSDA_OFF_INSTR);

    // address decode and readback
    always_comb
    begin
        addr_ok = 1'b1;
        wr_ro   = 1'b0;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            `CSDA_OFF_CTRL:
            begin
                rd_mux[`CSDA_CTRL_EXT] = ext_en_r;
                rd_mux[`CSDA_CTRL_TWO] = two_word_r;
            end
            `CSDA_OFF_INSTR:
            begin
                rd_mux[15:0]            = instr_r;
                rd_mux[`CSDA_INSTR_BUSY] = busy;
            end
            `CSDA_OFF_WORK:   rd_mux[7:0] = work_r;
            `CSDA_OFF_STATUS:
            begin
                rd_mux[`CSDA_STAT_C]  = carry_r;
                rd_mux[`CSDA_STAT_DC] = dcarry_r;
            end
            `CSDA_OFF_BANK:   rd_mux[BANK_W-1:0] = bank_r;
            `CSDA_OFF_INDEX:  rd_mux[ADDR_W-1:0] = index_r;
            `CSDA_OFF_RESULT:
            begin
                rd_mux[`CSDA_RES_SKIP]                      = skip_r;
                rd_mux[`CSDA_RES_CYC_LSB+1:`CSDA_RES_CYC_LSB] = cycles_r;
                rd_mux[`CSDA_RES_BAD]                       = bad_r;
                rd_mux[`CSDA_RES_EA_LSB+ADDR_W-1:`CSDA_RES_EA_LSB] = file_addr;
                wr_ro = 1'b1;
            end
            default:          addr_ok = 1'b0;
        endcase
    end

    // no wait state: ready, data and error registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= apb_setup;
            // unmapped, read-only target, or any write while executing
            pslverr <= apb_setup & (~addr_ok | (pwrite & (wr_ro | busy)));
            prdata  <= (apb_setup & ~pwrite & addr_ok) ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // software configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_en_r   <= 1'b0;
            two_word_r <= 1'b0;
            bank_r     <= `CSDA_RST_BANK;
            index_r    <= `CSDA_RST_INDEX;
        end
        else if (wr_ok)
        begin
            case (paddr)
                `CSDA_OFF_CTRL:
                begin
                    ext_en_r   <= pwdata[`CSDA_CTRL_EXT];
                    two_word_r <= pwdata[`CSDA_CTRL_TWO];
                end
                `CSDA_OFF_BANK:  bank_r  <= pwdata[BANK_W-1:0];
                `CSDA_OFF_INDEX: index_r <= pwdata[ADDR_W-1:0];
                default:         ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // instruction latch and decode
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_r <= 16'h0000;
            kind_r  <= CSDA_K_BAD;
        end
        else if (start)
        begin
            instr_r <= pwdata[15:0];
            if (pwdata[15:0] == `CSDA_OP_DAA)
                kind_r <= CSDA_K_DAA;
            else if (pwdata[15:9] == `CSDA_OP_LT)
                kind_r <= CSDA_K_LT;
            else if (pwdata[15:9] == `CSDA_OP_GT)
                kind_r <= CSDA_K_GT;
            else if (pwdata[15:9] == `CSDA_OP_EQ)
                kind_r <= CSDA_K_EQ;
            else
                kind_r <= CSDA_K_BAD;
        end
    end

    // ----------------------------------------------------------------
    // effective address
    // ----------------------------------------------------------------
    assign f_lit = instr_r[7:0];

    always_comb
    begin
        if (instr_r[8])
            ea = {bank_r, f_lit};
        else if (ext_en_r && (f_lit <= `CSDA_INDEX_LIMIT))
            ea = ADDR_W'(index_r + ADDR_W'(f_lit));
        else if (f_lit <= `CSDA_INDEX_LIMIT)
            ea = {`CSDA_ACCESS_LOW, f_lit};
        else
            ea = {`CSDA_ACCESS_HIGH, f_lit};
    end

    // ----------------------------------------------------------------
    // compare and decimal adjust datapath
    // ----------------------------------------------------------------
    assign diff = {1'b0, file_rdata} - {1'b0, work_r};

    // condition from the borrow and the zero test of the subtraction
    always_comb
    begin
        case (kind_r)
            CSDA_K_GT: cmp_skip = ~diff[8] & (diff[7:0] != 8'h00);
            CSDA_K_LT: cmp_skip = diff[8];
            CSDA_K_EQ: cmp_skip = (diff[7:0] == 8'h00);
            default:   cmp_skip = 1'b0;
        endcase
    end

    // low and high nibble correctors
    csda_nibble_adj u_lo
    (
        .nib_in    (daa_op_r[3:0]),
        .force_fix (dcarry_r),
        .nib_out   (lo_adj),
        .fixed     (lo_fix)
    );

    csda_nibble_adj u_hi
    (
        .nib_in    (daa_op_r[7:4]),
        .force_fix (carry_r),
        .nib_out   (hi_adj),
        .fixed     (hi_fix)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CSDA_ST_IDLE: if (start) state_nxt = CSDA_ST_Q1;
            CSDA_ST_Q1:   state_nxt = CSDA_ST_Q2;
            CSDA_ST_Q2:   state_nxt = CSDA_ST_Q3;
            CSDA_ST_Q3:   state_nxt = CSDA_ST_Q4;
            CSDA_ST_Q4:   state_nxt = skip_r ? CSDA_ST_NOP : CSDA_ST_IDLE;
            CSDA_ST_NOP:
            begin
                // leave after the last q4 of the last no-op cycle
                if (q_phase[3] && (nop_left_r == `CSDA_NOP_ONE))
                    state_nxt = CSDA_ST_IDLE;
            end
            default:      state_nxt = CSDA_ST_IDLE;
        endcase
    end

    // state, phase and visible sequencing outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r   <= CSDA_ST_IDLE;
            q_phase   <= 4'h0;
            busy      <= 1'b0;
            nop_cycle <= 1'b0;
            file_rd   <= 1'b0;
            file_addr <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            busy      <= (state_nxt != CSDA_ST_IDLE);
            nop_cycle <= (state_nxt == CSDA_ST_NOP);
            // rotate q1..q4 while an instruction cycle runs
            if (state_nxt == CSDA_ST_IDLE)
                q_phase <= 4'h0;
            else if (state_nxt == CSDA_ST_Q1)
                q_phase <= 4'h1;
            else
                q_phase <= {q_phase[2:0], q_phase[3]};
            // only compares touch data memory, read in q2
            file_rd <= (state_nxt == CSDA_ST_Q2) && !kind_r[3] && !kind_r[4];
            if (state_r == CSDA_ST_Q1)
                file_addr <= ea;
        end
    end

    // ----------------------------------------------------------------
    // skip decision, no-op count and cycle tally
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            skip_r     <= 1'b0;
            nop_left_r <= 2'h0;
            cycles_r   <= 2'h0;
            bad_r      <= 1'b0;
        end
        else
        begin
            if (state_r == CSDA_ST_Q1)
            begin
                skip_r   <= 1'b0;
                cycles_r <= `CSDA_CYC_ONE;
                bad_r    <= kind_r[4];
            end
            // process data: condition evaluated from the q3 read
            if (state_r == CSDA_ST_Q3)
                skip_r <= cmp_skip;
            if (state_r == CSDA_ST_Q4 && skip_r)
            begin
                nop_left_r <= two_word_r ? `CSDA_NOP_TWO : `CSDA_NOP_ONE;
                cycles_r   <= 2'(`CSDA_CYC_ONE + (two_word_r ? `CSDA_NOP_TWO : `CSDA_NOP_ONE));
            end
            else if (state_r == CSDA_ST_NOP && q_phase[3])
                nop_left_r <= 2'(nop_left_r - 2'h1);
        end
    end

    // ----------------------------------------------------------------
    // decimal adjust pipeline and flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            daa_op_r  <= 8'h00;
            daa_res_r <= 8'h00;
            daa_c_r   <= 1'b0;
        end
        else
        begin
            // q2: read working register
            if (state_r == CSDA_ST_Q2)
                daa_op_r <= work_r;
            // q3: nibble correction, carry set only by a high fix
            if (state_r == CSDA_ST_Q3)
            begin
                daa_res_r <= {hi_adj, lo_adj};
                daa_c_r   <= hi_fix | carry_r;
            end
        end
    end

    // working register and flags; software writes are refused while busy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            work_r   <= `CSDA_RST_WORK;
            carry_r  <= 1'b0;
            dcarry_r <= 1'b0;
        end
        else if (state_r == CSDA_ST_Q4 && kind_r == CSDA_K_DAA)
        begin
            // q4: write back, digit carry untouched
            work_r  <= daa_res_r;
            carry_r <= daa_c_r;
        end
        else if (wr_ok && paddr == `CSDA_OFF_WORK)
            work_r <= pwdata[7:0];
        else if (wr_ok && paddr == `CSDA_OFF_STATUS)
        begin
            carry_r  <= pwdata[`CSDA_STAT_C];
            dcarry_r <= pwdata[`CSDA_STAT_DC];
        end
    end

endmodule : csda_core
`default_nettype wire

// ### test/csda_checker.sv
// port-level timing checks for the compare-skip / decimal adjust block
`timescale 1ns/1ns
`default_nettype none
module csda_checker
#(
    parameter int ADDR_W = 12   // data memory address width
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] file_addr,
    input wire logic              file_rd,
    input wire logic [3:0]        q_phase,
    input wire logic              nop_cycle,
    input wire logic              busy
);
    // ----------------------------------------------------------------
    // phase sequencing
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rd_q2; file_rd |-> q_phase == 4'b0010 && !nop_cycle; endproperty
    a_rd_q2: assert property (p_rd_q2) else $error("memory read outside q2");
    property p_first_q1; $rose(busy) |-> q_phase == 4'b0001 && !nop_cycle; endproperty
    a_first_q1: assert property (p_first_q1) else $error("instruction not opened by q1");
    property p_min_cycle; $rose(busy) |-> busy [*4]; endproperty
    a_min_cycle: assert property (p_min_cycle) else $error("instruction shorter than one cycle");
    property p_onehot; busy |-> $onehot(q_phase); endproperty
    a_onehot: assert property (p_onehot) else $error("phase not one-hot while busy");
    property p_end; $fell(busy) |-> $past(q_phase) == 4'b1000 && q_phase == 4'b0000; endproperty
    a_end: assert property (p_end) else $error("instruction ended off q4");
    // ----------------------------------------------------------------
    // substituted no-operation cycles
    // ----------------------------------------------------------------
    property p_nop_len; $rose(nop_cycle) |-> nop_cycle [*4] ##1 (q_phase == 4'b0001 || q_phase == 4'b0000); endproperty
    a_nop_len: assert property (p_nop_len) else $error("no-op cycle not four phases");
    property p_nop_start; $rose(nop_cycle) |-> $past(q_phase) == 4'b1000 && q_phase == 4'b0001; endproperty
    a_nop_start: assert property (p_nop_start) else $error("no-op not after q4");
    property p_nop_quiet; nop_cycle |-> !file_rd && busy; endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("activity during no-op");
    property p_addr_hold; q_phase[2] |-> $stable(file_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in q3");
endmodule : csda_checker
bind csda_core csda_checker #(.ADDR_W(ADDR_W)) csda_checker_inst (.pclk(pclk), .presetn(presetn),
    .file_addr(file_addr), .file_rd(file_rd), .q_phase(q_phase), .nop_cycle(nop_cycle), .busy(busy));
`default_nettype wire

// ### test/csda_bench.sv
// self-checking bench for the compare-skip / decimal adjust block
`timescale 1ns/1ns
`default_nettype none
`include "csda_cfg.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module csda_bench;
    // ----------------------------------------------------------------
    // signals and stimulus tables
    // ----------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, file_rd, nop_cycle, busy, ev, sk;
    logic [11:0] paddr, file_addr;
    logic [31:0] pwdata, prdata, rv;
    logic [7:0]  file_rdata;
    logic [3:0]  q_phase;
    int          err_count, tests_run;
    logic [6:0]  ops [3] = '{`CSDA_OP_LT, `CSDA_OP_EQ, `CSDA_OP_GT};
    logic [7:0]  fv [4] = '{8'h0f, 8'h10, 8'h11, 8'h80};
    // ext, bank bit, file address, expected effective address
    logic [21:0] at [6] = '{{2'b01, 8'h22, 12'h522}, {2'b00, 8'h30, 12'h030}, {2'b00, 8'h80, 12'hf80},
                            {2'b10, 8'h5f, 12'h15f}, {2'b10, 8'h60, 12'hf60}, {2'b11, 8'h22, 12'h522}};
    // working value, carry, digit carry, expected value, expected carry
    logic [18:0] dt [4] = '{{8'ha5, 2'b00, 8'h05, 1'b1}, {8'h9a, 2'b00, 8'h90, 1'b0},
                            {8'h12, 2'b11, 8'h78, 1'b1}, {8'h99, 2'b00, 8'h99, 1'b0}};
    csda_core csda_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata), .q_phase(q_phase),
        .nop_cycle(nop_cycle), .busy(busy));
    // ----------------------------------------------------------------
    // clock, watchdog and bus tasks
    // ----------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    initial
    begin
        #1000000;
        err_count++;
        give_verdict();
    end
    // one apb transfer; read data and error kept in rv and ev
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rv = prdata;
        ev = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) err_count++;
    endtask : apb
    // wait for the instruction to retire, then fetch its result word
    task automatic poll;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `CSDA_OFF_INSTR, 32'h0);
            n++;
        end
        while (rv[`CSDA_INSTR_BUSY] !== 1'b0 && n < 20);
        if (n >= 20) err_count++;
        apb(1'b0, `CSDA_OFF_RESULT, 32'h0);
    endtask : poll
    task automatic exec(input logic [15:0] op);
        apb(1'b1, `CSDA_OFF_INSTR, {16'h0, op});
        poll();
    endtask : exec
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        err_count = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        file_rdata = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CSDA_OFF_WORK, 32'h0);
        `CHK(rv, 32'h0)
        // every compare kind against values around and above the working value
        apb(1'b1, `CSDA_OFF_STATUS, 32'h3);
        apb(1'b1, `CSDA_OFF_WORK, 32'h10);
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 4; i++)
            begin
                file_rdata <= fv[i];
                exec({ops[k], 1'b0, 8'h01});
                sk = (k == 0) ? (fv[i] < 8'h10) : (k == 1) ? (fv[i] == 8'h10) : (fv[i] > 8'h10);
                `CHK(rv[0], sk)
                `CHK(rv[2:1], sk ? 2'h2 : 2'h1)
            end
        apb(1'b0, `CSDA_OFF_STATUS, 32'h0);
        `CHK(rv, 32'h3)
        // skip over a two-word instruction, then a compare that does not skip
        apb(1'b1, `CSDA_OFF_CTRL, 32'h2);
        exec({`CSDA_OP_GT, 9'h001});
        `CHK(rv[2:0], 3'h7)
        exec({`CSDA_OP_LT, 9'h001});
        `CHK(rv[2:0], 3'h2)
        // bank, access bank and indexed addressing at the 5fh boundary
        apb(1'b1, `CSDA_OFF_BANK, 32'h5);
        apb(1'b1, `CSDA_OFF_INDEX, 32'h100);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `CSDA_OFF_CTRL, {31'h0, at[i][21]});
            exec({`CSDA_OP_EQ, at[i][20:12]});
            `CHK(rv[27:16], at[i][11:0])
        end
        // decimal adjust cases
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `CSDA_OFF_WORK, {24'h0, dt[i][18:11]});
            apb(1'b1, `CSDA_OFF_STATUS, {30'h0, dt[i][9], dt[i][10]});
            exec(`CSDA_OP_DAA);
            `CHK(rv[2:0], 3'h2)
            apb(1'b0, `CSDA_OFF_WORK, 32'h0);
            `CHK(rv, {24'h0, dt[i][8:1]})
            apb(1'b0, `CSDA_OFF_STATUS, 32'h0);
            `CHK(rv, {30'h0, dt[i][9], dt[i][0]})
        end
        // write refused while busy, then an unknown opcode
        apb(1'b1, `CSDA_OFF_INSTR, {16'h0, `CSDA_OP_GT, 9'h001});
        apb(1'b1, `CSDA_OFF_WORK, 32'h55);
        `CHK(ev, 1'b1)
        poll();
        // the refused write must have left the working register alone
        apb(1'b0, `CSDA_OFF_WORK, 32'h0);
        `CHK(rv, 32'h99)
        exec(16'hffff);
        `CHK(rv[3], 1'b1)
        // result word is read-only, unmapped offsets answer with an error and zero
        apb(1'b1, `CSDA_OFF_RESULT, 32'hf);
        `CHK(ev, 1'b1)
        apb(1'b0, 12'h01c, 32'h0);
        `CHK({ev, rv}, {1'b1, 32'h0})
        give_verdict();
    end
endmodule : csda_bench
`default_nettype wire
